//--- core/csu_config_store.sv
`timescale 1ns/1ps
`include "csu_defs.svh"

module csu_config_store (
   input  wire logic                   clk_in,
   input  wire logic                   reset_in,
   input  wire logic                   erase_all_in,
   input  wire logic                   param_wr_in,
   input  wire logic [3:0]             param_addr_in,
   input  wire csu_pkg::csu_word_t     param_data_in,
   input  wire logic                   store_all_in,
   input  wire logic                   img_start_in,
   input  wire logic                   img_wr_in,
   input  wire logic [`CSU_IDX_W-1:0]  img_addr_in,
   input  wire csu_pkg::csu_word_t     img_data_in,
   input  wire logic                   img_done_in,
   input  wire logic [3:0]             cfg_rd_addr_in,
   output csu_pkg::csu_word_t          cfg_rd_data_out,
   output csu_pkg::csu_word_t          pin_cfg_out,
   output logic                        ready_out,
   output logic                        busy_out,
   output logic                        alert_out,
   output logic                        cfg_bad_out,
   output logic                        active_bank_out,
   input  wire logic                   tck_in,
   input  wire logic                   tms_in,
   input  wire logic                   tdi_in,
   output logic                        tdo_out,
   output logic                        tdo_oe_out,
   input  wire logic [`CSU_BS_W-1:0]   bs_pins_in,
   output logic      [`CSU_BS_W-1:0]   bs_drive_out,
   output logic                        bs_oe_out
);
   import csu_pkg::*;

   // ==========================================================
   // Helpers
   function automatic csu_word_t csu_add(input csu_word_t a, input csu_word_t b);
      csu_add = a + b;
   endfunction

   // Sequence numbers wrap, so newer means a short forward distance
   function automatic logic csu_newer(input logic [`CSU_SEQ_W-1:0] a,
                                      input logic [`CSU_SEQ_W-1:0] b);
      logic [`CSU_SEQ_W-1:0] d;
      d = a - b;
      csu_newer = (d != 8'h00) && !d[`CSU_SEQ_W-1];
   endfunction

   // ==========================================================
   // Storage: working RAM and two flash banks with commit marks
   // Flash and marks are nonvolatile: reset leaves them alone
   csu_word_t              ram_mem [`CSU_WORDS];
   csu_word_t              fl_mem  [2][`CSU_WORDS+1];
   logic                   mark_ok_ff  [2];
   logic [`CSU_SEQ_W-1:0]  mark_seq_ff [2];

   csu_state_e             st_ff;
   logic [`CSU_IDX_W-1:0]  idx_ff;
   csu_word_t              sum_ff;
   logic                   cur_ff;
   logic                   cur_ok_ff;
   logic                   tgt;
   logic                   fl_we;
   logic [`CSU_IDX_W-1:0]  fl_idx;
   csu_word_t              fl_wd;
   csu_word_t              fl_rd;
   logic                   sel_bank;
   logic                   sel_any;
   logic                   param_ok;
   logic                   chk_bad;

   assign tgt      = cur_ok_ff ? ~cur_ff : 1'b0;
   assign fl_rd    = fl_mem[cur_ff][idx_ff];
   assign param_ok = param_wr_in && (st_ff == CSU_IDLE || st_ff == CSU_IMG);
   assign chk_bad  = (sum_ff != fl_mem[cur_ff][`CSU_CHK_IDX]);
   assign sel_any  = mark_ok_ff[0] || mark_ok_ff[1];

   always_comb begin
      if (mark_ok_ff[0] && mark_ok_ff[1]) begin
         sel_bank = csu_newer(mark_seq_ff[1], mark_seq_ff[0]); // RL17
      end else begin
         sel_bank = mark_ok_ff[1];
      end
   end

   // ==========================================================
   // Flash write port
   always_comb begin
      fl_we  = 1'b0;
      fl_idx = idx_ff;
      fl_wd  = sum_ff;
      if (st_ff == CSU_STORE) begin
         fl_we = 1'b1; // RL2
         if (idx_ff != `CSU_CHK_IDX) begin
            fl_wd = ram_mem[idx_ff[3:0]];
         end
      end else if (st_ff == CSU_IMG && img_wr_in && img_addr_in <= `CSU_CHK_IDX) begin
         fl_we  = 1'b1; // RL4
         fl_idx = img_addr_in;
         fl_wd  = img_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (fl_we) begin
         fl_mem[tgt][fl_idx] <= fl_wd;
      end
   end

   // ==========================================================
   // Commit marks: target invalid while written, old erased last
   always_ff @(posedge clk_in) begin
      if (erase_all_in) begin
         mark_ok_ff[0] <= 1'b0;
         mark_ok_ff[1] <= 1'b0;
      end else if (!reset_in) begin
         if (st_ff == CSU_IDLE && (store_all_in || img_start_in)) begin
            mark_ok_ff[tgt] <= 1'b0; // RL15
         end else if (st_ff == CSU_MARK) begin
            mark_ok_ff[tgt]  <= 1'b1; // RL15
            mark_seq_ff[tgt] <= cur_ok_ff ? mark_seq_ff[cur_ff] + 8'h01 : `CSU_SEQ_FIRST;
         end else if (st_ff == CSU_ERASE && cur_ok_ff) begin
            mark_ok_ff[cur_ff] <= 1'b0; // RL15
         end
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_ff     <= CSU_SEL;
         idx_ff    <= 5'h00;
         sum_ff    <= `CSU_WORD_ZERO;
         cur_ff    <= 1'b0;
         cur_ok_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            CSU_SEL: begin
               cur_ff    <= sel_bank; // RL17
               cur_ok_ff <= sel_any;
               idx_ff    <= 5'h00;
               sum_ff    <= `CSU_WORD_ZERO;
               st_ff     <= sel_any ? CSU_LOAD : CSU_IDLE; // RL5
            end
            CSU_LOAD: begin
               sum_ff <= csu_add(sum_ff, fl_rd);
               idx_ff <= idx_ff + 5'h01;
               if (idx_ff == `CSU_LAST_CFG) begin
                  st_ff <= CSU_CHK;
               end
            end
            CSU_CHK: begin
               st_ff <= CSU_IDLE;
            end
            CSU_IDLE: begin
               idx_ff <= 5'h00;
               sum_ff <= `CSU_WORD_ZERO;
               if (store_all_in) begin
                  st_ff <= CSU_STORE; // RL2
               end else if (img_start_in) begin
                  st_ff <= CSU_IMG; // RL4
               end
            end
            CSU_STORE: begin
               idx_ff <= idx_ff + 5'h01;
               if (idx_ff == `CSU_CHK_IDX) begin
                  st_ff <= CSU_MARK;
               end else begin
                  sum_ff <= csu_add(sum_ff, ram_mem[idx_ff[3:0]]);
               end
            end
            CSU_IMG: begin
               if (img_done_in) begin
                  st_ff <= CSU_MARK;
               end
            end
            CSU_MARK: begin
               st_ff <= CSU_ERASE;
            end
            CSU_ERASE: begin
               // Next write goes to the other bank; RAM stays as it was
               cur_ff    <= tgt; // RL6
               cur_ok_ff <= 1'b1;
               st_ff     <= CSU_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Working RAM: live values, filled by host or by reload
   always_ff @(posedge clk_in) begin
      if (st_ff == CSU_LOAD) begin
         ram_mem[idx_ff[3:0]] <= fl_rd; // RL17
      end else if (st_ff == CSU_CHK && chk_bad) begin
         for (int i = 0; i < `CSU_WORDS; i++) begin
            ram_mem[i] <= `CSU_WORD_ZERO; // RL16
         end
      end else if (param_ok) begin
         ram_mem[param_addr_in] <= param_data_in; // RL1
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cfg_rd_data_out <= `CSU_WORD_ZERO;
      end else begin
         cfg_rd_data_out <= ram_mem[cfg_rd_addr_in]; // RL7
      end
   end

   // Pin roles are latched at reload only, so a live edit waits for reset
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pin_cfg_out <= `CSU_WORD_ZERO;
      end else if (st_ff == CSU_CHK) begin
         pin_cfg_out <= chk_bad ? `CSU_WORD_ZERO : ram_mem[`CSU_PIN_IDX]; // RL8
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         alert_out   <= 1'b0;
         cfg_bad_out <= 1'b0;
      end else if (st_ff == CSU_CHK && chk_bad) begin
         alert_out   <= 1'b1; // RL16
         cfg_bad_out <= 1'b1;
      end
   end

   assign ready_out       = (st_ff == CSU_IDLE) || (st_ff == CSU_IMG);
   assign busy_out        = !ready_out;
   assign active_bank_out = cur_ff;

   // ==========================================================
   // Test port, with no route into the configuration store
   csu_tap u_tap (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .tck_in       (tck_in),
      .tms_in       (tms_in),
      .tdi_in       (tdi_in),
      .tdo_out      (tdo_out),
      .tdo_oe_out   (tdo_oe_out),
      .bs_pins_in   (bs_pins_in),
      .bs_drive_out (bs_drive_out),
      .bs_oe_out    (bs_oe_out)
   );

   // ==========================================================
   // Checks
   property p_ram_only;
      @(posedge clk_in) disable iff (reset_in)
      param_ok |-> !(fl_we && st_ff != CSU_IMG) ##1 ram_mem[$past(param_addr_in)] == $past(param_data_in);
   endproperty
   a_ram_only: assert property (p_ram_only) else $error("param write leaked"); // RL1

   property p_store;
      @(posedge clk_in) disable iff (reset_in)
      (st_ff == CSU_IDLE && store_all_in) |=> (st_ff == CSU_STORE && fl_we)[*8];
   endproperty
   a_store: assert property (p_store) else $error("store did not write flash"); // RL2

   property p_image;
      @(posedge clk_in) disable iff (reset_in)
      (st_ff == CSU_IMG && img_wr_in && img_addr_in <= `CSU_CHK_IDX && !img_done_in)
         |=> fl_mem[tgt][$past(img_addr_in)] == $past(img_data_in);
   endproperty
   a_image: assert property (p_image) else $error("image word lost"); // RL4

   property p_img_inert;
      @(posedge clk_in) disable iff (reset_in)
      (st_ff == CSU_IMG) |=> $stable(pin_cfg_out) && !$rose(alert_out);
   endproperty
   a_img_inert: assert property (p_img_inert) else $error("image took effect early"); // RL5

   property p_pin_hold;
      @(posedge clk_in) disable iff (reset_in)
      (st_ff != CSU_CHK) |=> $stable(pin_cfg_out);
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin roles changed live"); // RL8

   property p_live;
      @(posedge clk_in) disable iff (reset_in)
      (param_ok && cfg_rd_addr_in == param_addr_in) ##1 (cfg_rd_addr_in == $past(param_addr_in))
         |=> cfg_rd_data_out == $past(param_data_in, 2);
   endproperty
   a_live: assert property (p_live) else $error("RAM value not live"); // RL7

   property p_erase_late;
      @(posedge clk_in) disable iff (reset_in)
      (st_ff == CSU_ERASE) |-> mark_ok_ff[tgt] && $past(st_ff) == CSU_MARK;
   endproperty
   a_erase_late: assert property (p_erase_late) else $error("old bank erased early"); // RL15

   property p_bad_sum;
      @(posedge clk_in) disable iff (reset_in)
      (st_ff == CSU_CHK && chk_bad) |=> alert_out && cfg_bad_out && pin_cfg_out == 16'h0000;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad checksum not flagged"); // RL16

   property p_pick;
      @(posedge clk_in) disable iff (reset_in)
      // Sampled reset too: the release edge still shows the held select state
      (!reset_in && st_ff == CSU_SEL && sel_any) |=> st_ff == CSU_LOAD
         && cur_ff == $past(sel_bank) && mark_ok_ff[cur_ff] ##17 st_ff == CSU_IDLE;
   endproperty
   a_pick: assert property (p_pick) else $error("wrong bank reloaded"); // RL17
endmodule

//--- core/csu_defs.svh
// Operation
// RL1: Parameter writes touch only the working RAM
// RL2: Store command copies whole RAM into flash
// RL3: Host sends all parameters before storing
// RL4: Direct image writes go straight into flash
// RL5: Direct image becomes active after next reset
// RL6: Old configuration keeps running until reset
// RL7: RAM thresholds and timeouts apply immediately
// RL8: Pin functions change only after a reset
// RL9: Programming tool owns the bus alone
// RL10: Programmer writes one device at a time
// RL11: No reset during programming, flash may corrupt
// RL12: Production programming uses the direct image
// RL13: Test port is a boundary scan port
// RL14: Test port cannot write the configuration
// RL15: Two banks; old erased after new commits
// RL16: Bad checksum discards config, raises alert, flags
// RL17: Reset loads newest committed bank into RAM
`ifndef CSU_DEFS_SVH
`define CSU_DEFS_SVH

// ==========================================================
// Configuration image layout
`define CSU_WORDS     16
`define CSU_IDX_W     5
`define CSU_PIN_IDX   4'hF
`define CSU_CHK_IDX   5'h10
`define CSU_LAST_CFG  5'h0F
`define CSU_SEQ_W     8
`define CSU_SEQ_FIRST 8'h01
`define CSU_WORD_ZERO 16'h0000

// ==========================================================
// Test port
`define CSU_BS_W      8
`define CSU_IR_W      2
`define CSU_IR_EXTEST 2'h0
`define CSU_IR_SAMPLE 2'h1
`define CSU_IR_BYPASS 2'h3

`endif

//--- core/csu_pkg.sv
package csu_pkg;
   typedef logic [15:0] csu_word_t;

   // Gray along select, load, check, idle, store, mark, erase
   typedef enum logic [2:0] {
      CSU_SEL   = 3'h0,
      CSU_LOAD  = 3'h1,
      CSU_CHK   = 3'h3,
      CSU_IDLE  = 3'h2,
      CSU_STORE = 3'h6,
      CSU_MARK  = 3'h7,
      CSU_ERASE = 3'h5,
      CSU_IMG   = 3'h4
   } csu_state_e;

   typedef enum logic [3:0] {
      CSU_TLR = 4'h0, CSU_RTI = 4'h1, CSU_SDS = 4'h3, CSU_CDR = 4'h2,
      CSU_SDR = 4'h6, CSU_E1D = 4'h7, CSU_PDR = 4'h5, CSU_E2D = 4'h4,
      CSU_UDR = 4'hC, CSU_SIS = 4'hD, CSU_CIR = 4'hF, CSU_SIR = 4'hE,
      CSU_E1I = 4'hA, CSU_PIR = 4'hB, CSU_E2I = 4'h9, CSU_UIR = 4'h8
   } csu_tap_e;
endpackage

//--- core/csu_tap.sv
`timescale 1ns/1ps
`include "csu_defs.svh"

module csu_tap (
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  tck_in,
   input  wire logic                  tms_in,
   input  wire logic                  tdi_in,
   output logic                       tdo_out,
   output logic                       tdo_oe_out,
   input  wire logic [`CSU_BS_W-1:0]  bs_pins_in,
   output logic      [`CSU_BS_W-1:0]  bs_drive_out,
   output logic                       bs_oe_out
);
   import csu_pkg::*;

   // ==========================================================
   // Test clock edges, sampled on the device clock
   logic                  tck_q_ff;
   logic                  rise;
   logic                  fall;
   csu_tap_e              tap_ff;
   csu_tap_e              nxt_tap;
   logic [`CSU_IR_W-1:0]  ir_sh_ff;
   logic [`CSU_IR_W-1:0]  ir_ff;
   logic [`CSU_BS_W-1:0]  bs_sh_ff;
   logic                  byp_ff;

   assign rise = tck_in & ~tck_q_ff;
   assign fall = ~tck_in & tck_q_ff;

   always_ff @(posedge clk_in) begin
      tck_q_ff <= reset_in ? 1'b0 : tck_in;
   end

   // ==========================================================
   // Controller
   always_comb begin
      unique case (tap_ff)
         CSU_TLR: nxt_tap = tms_in ? CSU_TLR : CSU_RTI;
         CSU_RTI: nxt_tap = tms_in ? CSU_SDS : CSU_RTI;
         CSU_SDS: nxt_tap = tms_in ? CSU_SIS : CSU_CDR;
         CSU_CDR: nxt_tap = tms_in ? CSU_E1D : CSU_SDR;
         CSU_SDR: nxt_tap = tms_in ? CSU_E1D : CSU_SDR;
         CSU_E1D: nxt_tap = tms_in ? CSU_UDR : CSU_PDR;
         CSU_PDR: nxt_tap = tms_in ? CSU_E2D : CSU_PDR;
         CSU_E2D: nxt_tap = tms_in ? CSU_UDR : CSU_SDR;
         CSU_UDR: nxt_tap = tms_in ? CSU_SDS : CSU_RTI;
         CSU_SIS: nxt_tap = tms_in ? CSU_TLR : CSU_CIR;
         CSU_CIR: nxt_tap = tms_in ? CSU_E1I : CSU_SIR;
         CSU_SIR: nxt_tap = tms_in ? CSU_E1I : CSU_SIR;
         CSU_E1I: nxt_tap = tms_in ? CSU_UIR : CSU_PIR;
         CSU_PIR: nxt_tap = tms_in ? CSU_E2I : CSU_PIR;
         CSU_E2I: nxt_tap = tms_in ? CSU_UIR : CSU_SIR;
         CSU_UIR: nxt_tap = tms_in ? CSU_SDS : CSU_RTI;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tap_ff <= CSU_TLR;
      end else if (rise) begin
         tap_ff <= nxt_tap; // RL13
      end
   end

   // ==========================================================
   // Instruction register
   always_ff @(posedge clk_in) begin
      if (reset_in || (rise && tap_ff == CSU_TLR)) begin
         ir_sh_ff <= `CSU_IR_BYPASS;
         ir_ff    <= `CSU_IR_BYPASS;
      end else if (rise) begin
         if (tap_ff == CSU_CIR) begin
            ir_sh_ff <= 2'h1;
         end else if (tap_ff == CSU_SIR) begin
            ir_sh_ff <= {tdi_in, ir_sh_ff[`CSU_IR_W-1:1]};
         end
         if (tap_ff == CSU_UIR) begin
            ir_ff <= ir_sh_ff;
         end
      end
   end

   // ==========================================================
   // Boundary and bypass data registers
   // Only pins are reachable here; nothing feeds the configuration store
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         bs_sh_ff     <= 8'h00;
         bs_drive_out <= 8'h00;
         byp_ff       <= 1'b0;
      end else if (rise) begin
         if (tap_ff == CSU_CDR) begin
            bs_sh_ff <= bs_pins_in; // RL13
            byp_ff   <= 1'b0;
         end else if (tap_ff == CSU_SDR) begin
            bs_sh_ff <= {tdi_in, bs_sh_ff[`CSU_BS_W-1:1]};
            byp_ff   <= tdi_in;
         end
         if (tap_ff == CSU_UDR && ir_ff != `CSU_IR_BYPASS) begin
            bs_drive_out <= bs_sh_ff; // RL14
         end
      end
   end

   assign bs_oe_out = (ir_ff == `CSU_IR_EXTEST);

   // Output changes on the falling test clock edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tdo_out    <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else if (fall) begin
         tdo_oe_out <= (tap_ff == CSU_SDR) || (tap_ff == CSU_SIR);
         if (tap_ff == CSU_SIR) begin
            tdo_out <= ir_sh_ff[0];
         end else if (ir_ff == `CSU_IR_BYPASS || ir_ff == 2'h2) begin
            tdo_out <= byp_ff;
         end else begin
            tdo_out <= bs_sh_ff[0];
         end
      end
   end
endmodule

//--- test/csu_host_model.sv
`timescale 1ns/1ps
`include "csu_defs.svh"
// ==================================================
// Host side: management bus host or flash programmer
module csu_host_model (
   input  wire logic                   clk_in,
   input  wire csu_pkg::csu_word_t     rd_data_in,
   output logic                        param_wr_out,
   output logic [3:0]                  param_addr_out,
   output csu_pkg::csu_word_t          param_data_out,
   output logic                        store_all_out,
   output logic                        img_start_out,
   output logic                        img_wr_out,
   output logic [`CSU_IDX_W-1:0]       img_addr_out,
   output csu_pkg::csu_word_t          img_data_out,
   output logic                        img_done_out,
   output logic [3:0]                  cfg_rd_addr_out
);
   import csu_pkg::*;

   // Sole master on a segment with one device, so no arbitration is modelled
   initial begin
      param_wr_out    = 1'b0;
      param_addr_out  = 4'h0;
      param_data_out  = 16'h0000;
      store_all_out   = 1'b0;
      img_start_out   = 1'b0;
      img_wr_out      = 1'b0;
      img_addr_out    = 5'h00;
      img_data_out    = 16'h0000;
      img_done_out    = 1'b0;
      cfg_rd_addr_out = 4'h0;
   end

   task automatic param_write(input logic [3:0] a, input csu_word_t d);
      @(posedge clk_in);
      param_wr_out   <= 1'b1;
      param_addr_out <= a;
      param_data_out <= d;
      @(posedge clk_in);
      param_wr_out   <= 1'b0;
      param_data_out <= ~d; // Released data never keeps its last value
   endtask

   // Only called once every parameter has been sent
   task automatic store_all();
      @(posedge clk_in);
      store_all_out <= 1'b1;
      @(posedge clk_in);
      store_all_out <= 1'b0;
   endtask

   // Image words 0 to n straight into flash; close low leaves the session hanging
   task automatic image(input csu_word_t base, input int n, input logic good,
                        input logic close);
      csu_word_t sum;
      csu_word_t d;
      sum = 16'h0000;
      @(posedge clk_in);
      img_start_out <= 1'b1;
      for (int i = 0; i <= n; i++) begin
         d = (i < 16) ? base + i[15:0] : (good ? sum : ~sum);
         sum = sum + ((i < 16) ? d : 16'h0000);
         @(posedge clk_in);
         img_start_out <= 1'b0;
         img_wr_out    <= 1'b1;
         img_addr_out  <= i[4:0];
         img_data_out  <= d;
      end
      @(posedge clk_in);
      img_wr_out   <= 1'b0;
      img_data_out <= ~d;
      img_done_out <= close;
      @(posedge clk_in);
      img_done_out <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask

   task automatic read_word(input logic [3:0] a, output csu_word_t d);
      @(posedge clk_in);
      cfg_rd_addr_out <= a;
      @(posedge clk_in);
      @(negedge clk_in);
      d = rd_data_in;
   endtask
endmodule

//--- test/test_config_store_update.sv
`timescale 1ns/1ps
`include "csu_defs.svh"
// ==================================================
// Self-checking bench
module test_config_store_update;
   import csu_pkg::*;
   logic                  clk_in;
   logic                  reset_in     = 1'b1;
   logic                  erase_all_in = 1'b1;
   logic                  tck_in       = 1'b0;
   logic                  tms_in       = 1'b1;
   logic                  tdi_in       = 1'b0;
   logic [`CSU_BS_W-1:0]  bs_pins_in   = 8'h5A;
   logic                  param_wr_in, store_all_in, img_start_in, img_wr_in, img_done_in;
   logic [3:0]            param_addr_in, cfg_rd_addr_in;
   logic [`CSU_IDX_W-1:0] img_addr_in;
   csu_word_t             param_data_in, img_data_in, cfg_rd_data_out, pin_cfg_out;
   logic                  ready_out, busy_out, alert_out, cfg_bad_out, active_bank_out;
   logic                  tdo_out, tdo_oe_out, bs_oe_out;
   logic [`CSU_BS_W-1:0]  bs_drive_out;
   int                    n_errors    = 0;
   int                    comparisons = 0;
   int                    cycles      = 0;

   csu_config_store uut (
      .clk_in, .reset_in, .erase_all_in, .param_wr_in, .param_addr_in, .param_data_in,
      .store_all_in, .img_start_in, .img_wr_in, .img_addr_in, .img_data_in, .img_done_in,
      .cfg_rd_addr_in, .cfg_rd_data_out, .pin_cfg_out, .ready_out, .busy_out, .alert_out,
      .cfg_bad_out, .active_bank_out, .tck_in, .tms_in, .tdi_in, .tdo_out, .tdo_oe_out,
      .bs_pins_in, .bs_drive_out, .bs_oe_out
   );

   csu_host_model host (
      .clk_in(clk_in), .rd_data_in(cfg_rd_data_out), .param_wr_out(param_wr_in),
      .param_addr_out(param_addr_in), .param_data_out(param_data_in),
      .store_all_out(store_all_in), .img_start_out(img_start_in), .img_wr_out(img_wr_in),
      .img_addr_out(img_addr_in), .img_data_out(img_data_in), .img_done_out(img_done_in),
      .cfg_rd_addr_out(cfg_rd_addr_in)
   );

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // ==================================================
   // Shared helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic expect_word(input logic [3:0] a, input csu_word_t exp);
      csu_word_t w;
      host.read_word(a, w);
      check("cfg word", w, exp);
   endtask

   // Reload takes select, 16 loads and a check; 40 cycles is ample
   task automatic do_reset(input int n);
      int k;
      k = 0;
      @(posedge clk_in);
      reset_in <= 1'b1;
      repeat (n) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      while (ready_out !== 1'b1 && k < 40) begin
         @(negedge clk_in);
         k++;
      end
      check("ready after reset", {15'h0000, ready_out}, 16'h0001);
   endtask

   task automatic tck_bit(input logic m, input logic d);
      @(posedge clk_in);
      tms_in <= m;
      tdi_in <= d;
      @(posedge clk_in);
      tck_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      tck_in <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask

   // ==================================================
   // Scenarios
   task automatic t_blank();
      check("alert blank", {15'h0000, alert_out}, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         host.param_write(i[3:0], 16'hA000 + i[15:0]);
      end
      expect_word(4'h3, 16'hA003);
      expect_word(4'hF, 16'hA00F);
      check("pin cfg live", pin_cfg_out, 16'h0000);
   endtask

   task automatic t_store();
      int   n;
      n    = 0;
      host.store_all();
      @(negedge clk_in);
      while (busy_out === 1'b1 && n < 100) begin
         n++;
         @(negedge clk_in);
      end
      check("store busy cycles", n[15:0], 16'h0013);
      // A blank device commits its first store into bank 0
      check("bank first", {15'h0000, active_bank_out}, 16'h0000);
      host.param_write(4'h3, 16'h5555);
      expect_word(4'h3, 16'h5555);
      do_reset(2);
      expect_word(4'h3, 16'hA003);
      check("pin cfg reload", pin_cfg_out, 16'hA00F);
   endtask

   task automatic t_image();
      host.image(16'h3000, 16, 1'b1, 1'b1);
      check("ready after image", {15'h0000, ready_out}, 16'h0001);
      check("bank flip", {15'h0000, active_bank_out}, 16'h0001);
      expect_word(4'h3, 16'hA003);
      check("pin cfg held", pin_cfg_out, 16'hA00F);
      do_reset(2);
      expect_word(4'h3, 16'h3003);
      check("pin cfg image", pin_cfg_out, 16'h300F);
      check("alert good image", {15'h0000, alert_out}, 16'h0000);
   endtask

   // Reset in mid-session on purpose: the half-written bank must be ignored
   task automatic t_abort();
      host.image(16'h7000, 7, 1'b1, 1'b0);
      do_reset(2);
      expect_word(4'h3, 16'h3003);
      check("pin cfg old bank", pin_cfg_out, 16'h300F);
   endtask

   task automatic t_tap();
      logic [8:0]  walk     = 9'h05F;
      logic [21:0] scan_tms = 22'h1802C6;
      logic [21:0] scan_tdi = 22'h0C3000;
      for (int i = 0; i < 9; i++) begin
         tck_bit(walk[i], 1'b0);
      end
      check("tdo capture", {15'h0000, tdo_out}, 16'h0000);
      check("tdo enable", {15'h0000, tdo_oe_out}, 16'h0001);
      tck_bit(1'b0, 1'b1);
      check("tdo bypass one", {15'h0000, tdo_out}, 16'h0001);
      tck_bit(1'b0, 1'b0);
      check("tdo bypass zero", {15'h0000, tdo_out}, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         tck_bit(1'b1, 1'b1);
      end
      check("tdo idle", {15'h0000, tdo_oe_out}, 16'h0000);
      check("bs enable", {15'h0000, bs_oe_out}, 16'h0000);
      // Load external test, then shift a drive pattern over the captured pins
      for (int i = 0; i < 22; i++) begin
         tck_bit(scan_tms[i], scan_tdi[i]);
      end
      check("bs extest enable", {15'h0000, bs_oe_out}, 16'h0001);
      check("bs drive", {8'h00, bs_drive_out}, 16'h00C3);
      expect_word(4'h3, 16'h3003);
   endtask

   task automatic t_badsum();
      host.image(16'h9000, 16, 1'b0, 1'b1);
      do_reset(2);
      check("alert", {15'h0000, alert_out}, 16'h0001);
      check("status flag", {15'h0000, cfg_bad_out}, 16'h0001);
      expect_word(4'h3, 16'h0000);
      check("pin cfg cleared", pin_cfg_out, 16'h0000);
   endtask

   // ==================================================
   // Run control
   task automatic final_report();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         final_report();
      end
   end

   // Marks are nonvolatile, so the device is blanked once before anything else
   initial begin
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      erase_all_in <= 1'b0;
      do_reset(2);
      t_blank();
      t_store();
      t_image();
      t_abort();
      t_tap();
      t_badsum();
      final_report();
   end
endmodule
